// ==== inc/lc_pkg.sv ====
// Purpose: Shared constants and state type of the configurable logic cell.
// Assumes: 32-bit register port with byte addresses, one word per register.
// Notes:   Table contents and steering choices live in software registers.
package lc_pkg;

  localparam int unsigned LC_ADDR_W = 8;
  localparam int unsigned LC_DATA_W = 32;
  localparam int unsigned LC_FT_W   = 16;
  localparam int unsigned LC_TT_W   = 8;
  localparam int unsigned LC_MODE_W = 12;
  localparam int unsigned LC_STAT_W = 5;

  // Register byte addresses
  localparam logic [LC_ADDR_W-1:0] LC_FIRST_CFG_ADDR  = 8'h00;
  localparam logic [LC_ADDR_W-1:0] LC_SECOND_CFG_ADDR = 8'h04;
  localparam logic [LC_ADDR_W-1:0] LC_THIRD_CFG_ADDR  = 8'h08;
  localparam logic [LC_ADDR_W-1:0] LC_MODE_CFG_ADDR   = 8'h0C;
  localparam logic [LC_ADDR_W-1:0] LC_STATUS_ADDR     = 8'h10;

  // Mode register field positions
  localparam int unsigned LC_MODE_A_SEL     = 0;
  localparam int unsigned LC_MODE_B_SEL     = 1;
  localparam int unsigned LC_MODE_X_SRC_LSB = 2;
  localparam int unsigned LC_MODE_Y_SRC_LSB = 4;
  localparam int unsigned LC_MODE_X_LATCH   = 6;
  localparam int unsigned LC_MODE_Y_LATCH   = 7;
  localparam int unsigned LC_MODE_X_INIT    = 8;
  localparam int unsigned LC_MODE_Y_INIT    = 9;
  localparam int unsigned LC_MODE_X_OUT     = 10;
  localparam int unsigned LC_MODE_Y_OUT     = 11;

  // Storage data source codes
  localparam logic [1:0] LC_SRC_FIRST  = 2'h0;
  localparam logic [1:0] LC_SRC_SECOND = 2'h1;
  localparam logic [1:0] LC_SRC_THIRD  = 2'h2;
  localparam logic [1:0] LC_SRC_DIRECT = 2'h3;

  // Reset values
  localparam logic [LC_FT_W-1:0]   LC_FIRST_RST  = 16'h0000;
  localparam logic [LC_FT_W-1:0]   LC_SECOND_RST = 16'h0000;
  localparam logic [LC_TT_W-1:0]   LC_THIRD_RST  = 8'h00;
  localparam logic [LC_MODE_W-1:0] LC_MODE_RST   = 12'h000;
  localparam logic [LC_DATA_W-1:0] LC_RDATA_RST  = 32'h0000_0000;

  typedef struct packed {
    logic [LC_FT_W-1:0]   first_cfg;
    logic [LC_FT_W-1:0]   second_cfg;
    logic [LC_TT_W-1:0]   third_cfg;
    logic [LC_MODE_W-1:0] mode_cfg;
    logic                 trig_prev;
    logic                 store_x;
    logic                 store_y;
    logic                 comb_x;
    logic                 comb_y;
    logic                 third_out;
    logic [LC_DATA_W-1:0] rdata;
  } lc_state_t;

endpackage

// ==== hdl/lc_logic_cell.sv ====
// Purpose: Configurable logic cell with three lookup tables, steering
//          multiplexers and two shared-control storage elements.
// Assumes: All cell inputs are synchronous to ref_clk_in; the storage
//          trigger is sampled and its rising edge or level is detected.
// Notes:   Combinational table outputs are registered once at the ports.
//          Latch mode is a capture on every edge while the gate is high,
//          so a data change while the gate is still high is followed.
//          Set/reset and global init act at the edge, ahead of enable.
//
// Functional notes
// - First and second tables each pick one of sixteen stored bits by four inputs.
// - The third table picks one of eight stored bits by its three inputs.
// - Two third table inputs are muxed from a table output or a cell input.
// - With the steering above the cell forms any function of five inputs.
// - Both four-input tables plus one input feed the third for wide functions.
// - Three table outputs exist; the third table result also leaves on third_table_out.
// - Two storage elements capture table results or are used on their own.
// - The direct storage input may feed either storage element.
// - The dedicated third table input can pass through it to either element.
// - Both elements share one trigger, one enable and one set/reset line.
// - The global init signal also forces both elements to their init state.
// - Each element may be a level latch on the shared gate and enable.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module lc_logic_cell
  import lc_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic [LC_ADDR_W-1:0] reg_addr_in,
  input  wire logic [LC_DATA_W-1:0] reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [LC_DATA_W-1:0] reg_rdata_out,
  input  wire logic [3:0]           first_table_in,
  input  wire logic [3:0]           second_table_in,
  input  wire logic                 third_table_alt_a_in,
  input  wire logic                 third_table_alt_b_in,
  input  wire logic                 third_table_dedicated_input_in,
  input  wire logic                 direct_store_in,
  input  wire logic                 storage_trigger_in,
  input  wire logic                 storage_enable_in,
  input  wire logic                 set_reset_line_in,
  input  wire logic                 global_init_in,
  output logic                      comb_x_out,
  output logic                      comb_y_out,
  output logic                      store_x_out,
  output logic                      store_y_out,
  output logic                      third_table_out
);

  lc_state_t st_q;
  lc_state_t st_d;

  logic       first_val;
  logic       second_val;
  logic       third_a;
  logic       third_b;
  logic [2:0] third_idx;
  logic       third_val;
  logic       data_x;
  logic       data_y;
  logic       trig_rise;
  logic       force_init;
  logic       next_x;
  logic       next_y;

  ////////////////////////////////////////////////////////////////////////////
  // Lookup tables and steering

  lc_lut_pick #(.IDX_W(4)) u_first (
    .cfg_in  (st_q.first_cfg),
    .idx_in  (first_table_in),
    .bit_out (first_val)
  );

  lc_lut_pick #(.IDX_W(4)) u_second (
    .cfg_in  (st_q.second_cfg),
    .idx_in  (second_table_in),
    .bit_out (second_val)
  );

  lc_lut_pick #(.IDX_W(3)) u_third (
    .cfg_in  (st_q.third_cfg),
    .idx_in  (third_idx),
    .bit_out (third_val)
  );

  always_comb begin
    third_a = st_q.mode_cfg[LC_MODE_A_SEL] ? third_table_alt_a_in : first_val;
    third_b = st_q.mode_cfg[LC_MODE_B_SEL] ? third_table_alt_b_in : second_val;
    third_idx = {third_table_dedicated_input_in, third_b, third_a};
  end

  // Storage data source select
  function automatic logic pick_src(input logic [1:0] sel,
                                    input logic       f_v,
                                    input logic       g_v,
                                    input logic       h_v,
                                    input logic       d_v);
    logic r;
    r = f_v;
    case (sel)
      LC_SRC_FIRST:  r = f_v;
      LC_SRC_SECOND: r = g_v;
      LC_SRC_THIRD:  r = h_v;
      LC_SRC_DIRECT: r = d_v;
      default:       r = f_v;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage element steps

  // latch or edge step, element X
  lc_store_step u_step_x (
    .cur_in        (st_q.store_x),
    .data_in       (data_x),
    .latch_mode_in (st_q.mode_cfg[LC_MODE_X_LATCH]),
    .init_val_in   (st_q.mode_cfg[LC_MODE_X_INIT]),
    .init_now_in   (force_init),
    .enable_in     (storage_enable_in),
    .gate_in       (storage_trigger_in),
    .rise_in       (trig_rise),
    .next_out      (next_x)
  );

  // latch or edge step, element Y
  lc_store_step u_step_y (
    .cur_in        (st_q.store_y),
    .data_in       (data_y),
    .latch_mode_in (st_q.mode_cfg[LC_MODE_Y_LATCH]),
    .init_val_in   (st_q.mode_cfg[LC_MODE_Y_INIT]),
    .init_now_in   (force_init),
    .enable_in     (storage_enable_in),
    .gate_in       (storage_trigger_in),
    .rise_in       (trig_rise),
    .next_out      (next_y)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d = st_q;

    data_x = pick_src(st_q.mode_cfg[LC_MODE_X_SRC_LSB +: 2], first_val,
                      second_val, third_val, direct_store_in);
    data_y = pick_src(st_q.mode_cfg[LC_MODE_Y_SRC_LSB +: 2], first_val,
                      second_val, third_val, direct_store_in);

    trig_rise = storage_trigger_in & ~st_q.trig_prev;
    st_d.trig_prev = storage_trigger_in;

    force_init = set_reset_line_in | global_init_in;

    st_d.store_x = next_x;
    st_d.store_y = next_y;

    st_d.comb_x = st_q.mode_cfg[LC_MODE_X_OUT] ? third_val : first_val;
    st_d.comb_y = st_q.mode_cfg[LC_MODE_Y_OUT] ? third_val : second_val;
    st_d.third_out = third_val;

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        LC_FIRST_CFG_ADDR:  st_d.first_cfg  = reg_wdata_in[LC_FT_W-1:0];
        LC_SECOND_CFG_ADDR: st_d.second_cfg = reg_wdata_in[LC_FT_W-1:0];
        LC_THIRD_CFG_ADDR:  st_d.third_cfg  = reg_wdata_in[LC_TT_W-1:0];
        LC_MODE_CFG_ADDR:   st_d.mode_cfg   = reg_wdata_in[LC_MODE_W-1:0];
        default: begin
        end
      endcase
    end

    // Register reads, data valid for one cycle only
    st_d.rdata = LC_RDATA_RST;
    if (reg_rd_in) begin
      case (reg_addr_in)
        LC_FIRST_CFG_ADDR: begin
          st_d.rdata = {{(LC_DATA_W-LC_FT_W){1'b0}}, st_q.first_cfg};
        end
        LC_SECOND_CFG_ADDR: begin
          st_d.rdata = {{(LC_DATA_W-LC_FT_W){1'b0}}, st_q.second_cfg};
        end
        LC_THIRD_CFG_ADDR: begin
          st_d.rdata = {{(LC_DATA_W-LC_TT_W){1'b0}}, st_q.third_cfg};
        end
        LC_MODE_CFG_ADDR: begin
          st_d.rdata = {{(LC_DATA_W-LC_MODE_W){1'b0}}, st_q.mode_cfg};
        end
        LC_STATUS_ADDR: begin
          st_d.rdata = {{(LC_DATA_W-LC_STAT_W){1'b0}}, st_q.third_out,
                        st_q.comb_y, st_q.comb_x, st_q.store_y,
                        st_q.store_x};
        end
        default: begin
          st_d.rdata = LC_RDATA_RST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q.first_cfg  <= LC_FIRST_RST;
      st_q.second_cfg <= LC_SECOND_RST;
      st_q.third_cfg  <= LC_THIRD_RST;
      st_q.mode_cfg   <= LC_MODE_RST;
      st_q.trig_prev  <= 1'b0;
      st_q.store_x    <= 1'b0;
      st_q.store_y    <= 1'b0;
      st_q.comb_x     <= 1'b0;
      st_q.comb_y     <= 1'b0;
      st_q.third_out  <= 1'b0;
      st_q.rdata      <= LC_RDATA_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out   = st_q.rdata;
  assign comb_x_out      = st_q.comb_x;
  assign comb_y_out      = st_q.comb_y;
  assign store_x_out     = st_q.store_x;
  assign store_y_out     = st_q.store_y;
  assign third_table_out = st_q.third_out;

endmodule

////////////////////////////////////////////////////////////////////////////
// Single-bit table lookup, shared by all three tables

module lc_lut_pick
  import lc_pkg::*;
#(
  parameter int unsigned IDX_W = 4
)(
  input  wire logic [(2**IDX_W)-1:0] cfg_in,
  input  wire logic [IDX_W-1:0]      idx_in,
  output logic                       bit_out
);

  // Delay does not depend on the stored function
  assign bit_out = cfg_in[idx_in];

endmodule

////////////////////////////////////////////////////////////////////////////
// Next value of one storage element

module lc_store_step
  import lc_pkg::*;
(
  input  wire logic cur_in,
  input  wire logic data_in,
  input  wire logic latch_mode_in,
  input  wire logic init_val_in,
  input  wire logic init_now_in,
  input  wire logic enable_in,
  input  wire logic gate_in,
  input  wire logic rise_in,
  output logic      next_out
);

  // Init wins over enable; otherwise hold unless enabled
  always_comb begin
    next_out = cur_in;
    if (init_now_in) begin
      next_out = init_val_in;
    end else if (enable_in && (latch_mode_in ? gate_in : rise_in)) begin
      next_out = data_in;
    end
  end

endmodule

`default_nettype wire

// ==== sim/lc_nbr_model.sv ====
// Purpose: Neighbour cell driving the shared storage trigger net
// Assumes: Its output flop is clocked with the cell
// Notes:   Trigger lags the request by one cycle
`timescale 1ns/1ps
`default_nettype none
module lc_nbr_model (
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic req_in,
  output logic      trig_out
);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_out <= 1'h0;
    end else begin
      trig_out <= req_in;
    end
  end
endmodule
`default_nettype wire

// ==== sim/lc_monitor.sv ====
// Purpose: Port checker for the logic cell
// Assumes: Config is shadowed from register writes
// Notes:   Bound to every logic cell instance
`timescale 1ns/1ps
`default_nettype none
module lc_monitor
  import lc_pkg::*;
(
  input wire logic                 ref_clk_in,
  input wire logic                 arst_n_in,
  input wire logic [LC_ADDR_W-1:0] reg_addr_in,
  input wire logic [LC_DATA_W-1:0] reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic [3:0]           first_table_in,
  input wire logic [3:0]           second_table_in,
  input wire logic                 third_table_alt_a_in,
  input wire logic                 third_table_alt_b_in,
  input wire logic                 third_table_dedicated_input_in,
  input wire logic                 direct_store_in,
  input wire logic                 storage_trigger_in,
  input wire logic                 storage_enable_in,
  input wire logic                 set_reset_line_in,
  input wire logic                 global_init_in,
  input wire logic                 comb_x_out,
  input wire logic                 comb_y_out,
  input wire logic                 store_x_out,
  input wire logic                 store_y_out,
  input wire logic                 third_table_out
);
  logic [15:0] f_q, g_q;
  logic [7:0]  h_q;
  logic [11:0] m_q;
  logic        tp_q, f_v, g_v, h_v, xd, cap_x, frc;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {f_q, g_q, h_q, m_q, tp_q} <= '0;
    end else begin
      tp_q <= storage_trigger_in;
      if (reg_wr_in) begin
        case (reg_addr_in)
          LC_FIRST_CFG_ADDR:  f_q <= reg_wdata_in[15:0];
          LC_SECOND_CFG_ADDR: g_q <= reg_wdata_in[15:0];
          LC_THIRD_CFG_ADDR:  h_q <= reg_wdata_in[7:0];
          LC_MODE_CFG_ADDR:   m_q <= reg_wdata_in[11:0];
          default:            ;
        endcase
      end
    end
  end
  always_comb begin
    f_v = f_q[first_table_in];
    g_v = g_q[second_table_in];
    h_v = h_q[{third_table_dedicated_input_in,
               m_q[1] ? third_table_alt_b_in : g_v,
               m_q[0] ? third_table_alt_a_in : f_v}];
    case (m_q[3:2])
      LC_SRC_FIRST:  xd = f_v;
      LC_SRC_SECOND: xd = g_v;
      LC_SRC_THIRD:  xd = h_v;
      default:       xd = direct_store_in;
    endcase
    frc = set_reset_line_in || global_init_in;
    cap_x = !frc && storage_enable_in && storage_trigger_in
            && (m_q[6] || !tp_q);
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  first_lut_a: assert property (
    !m_q[10] |=> comb_x_out == $past(f_v)) else $error("first table");
  second_lut_a: assert property (
    !m_q[11] |=> comb_y_out == $past(g_v)) else $error("second table");
  third_lut_a: assert property (
    ##1 third_table_out == $past(h_v)) else $error("third table");
  third_route_a: assert property (
    m_q[10] |=> comb_x_out == $past(h_v)) else $error("third route");
  store_hold_a: assert property (
    !storage_enable_in && !frc |=> $stable(store_x_out)
    && $stable(store_y_out)) else $error("hold broken");
  store_init_a: assert property (
    frc && !reg_wr_in |=> {store_y_out, store_x_out} == m_q[9:8])
    else $error("init value");
  store_cap_a: assert property (
    cap_x |=> store_x_out == $past(xd)) else $error("capture");
  edge_only_a: assert property (
    !m_q[6] && tp_q && storage_trigger_in && !frc |=> $stable(store_x_out))
    else $error("edge capture");
endmodule
bind lc_logic_cell lc_monitor u_mon (.ref_clk_in, .arst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .first_table_in, .second_table_in,
  .third_table_alt_a_in, .third_table_alt_b_in,
  .third_table_dedicated_input_in, .direct_store_in, .storage_trigger_in,
  .storage_enable_in, .set_reset_line_in, .global_init_in, .comb_x_out,
  .comb_y_out, .store_x_out, .store_y_out, .third_table_out);
`default_nettype wire

// ==== sim/tb_lc_logic_cell.sv ====
// Purpose: Self-checking bench for the logic cell
// Assumes: Read data one cycle after the strobe
// Notes:   Trigger comes through the neighbour model
`timescale 1ns/1ps
`default_nettype none
module tb_lc_logic_cell
  import lc_pkg::*;
;
  localparam logic [15:0] FT = 16'hA5C3;
  localparam logic [15:0] GT = 16'h3C96;
  localparam logic [7:0]  TT = 8'hD4;
  logic       ref_clk_in = '0, arst_n_in = '0, reg_wr_in = '0, reg_rd_in = '0;
  logic [7:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [3:0] first_table_in = '0, second_table_in = '0;
  logic third_table_alt_a_in = '0, third_table_alt_b_in = '0;
  logic third_table_dedicated_input_in = '0, direct_store_in = '0;
  logic storage_enable_in = '0, set_reset_line_in = '0, global_init_in = '0;
  logic trig_req = '0, storage_trigger_in;
  logic comb_x_out, comb_y_out, store_x_out, store_y_out, third_table_out;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  lc_nbr_model u_nbr (.ref_clk_in, .arst_n_in, .req_in(trig_req),
    .trig_out(storage_trigger_in));
  lc_logic_cell u_dut (.ref_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .first_table_in, .second_table_in,
    .third_table_alt_a_in, .third_table_alt_b_in,
    .third_table_dedicated_input_in, .direct_store_in, .storage_trigger_in,
    .storage_enable_in, .set_reset_line_in, .global_init_in, .comb_x_out,
    .comb_y_out, .store_x_out, .store_y_out, .third_table_out);
  always #12.5 ref_clk_in = ~ref_clk_in;
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'h1, a, d};
    @(posedge ref_clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    {reg_rd_in, reg_addr_in} <= {1'h1, a};
    @(posedge ref_clk_in);
    reg_rd_in <= 1'h0;
    @(negedge ref_clk_in);
    chk(reg_rdata_out, e);
  endtask
  // Inputs {sr, init, enable, trigger request, direct} held two edges
  task automatic ph(input logic [4:0] v, input logic [1:0] e);
    @(posedge ref_clk_in);
    {set_reset_line_in, global_init_in, storage_enable_in, trig_req,
     direct_store_in} <= v;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(32'({store_x_out, store_y_out}), 32'(e));
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    arst_n_in <= 1'h1;
    wr(LC_STATUS_ADDR, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), '0);
    wr(LC_FIRST_CFG_ADDR, 32'(FT));
    wr(LC_SECOND_CFG_ADDR, 32'(GT));
    rd(LC_FIRST_CFG_ADDR, 32'(FT));
    rd(LC_SECOND_CFG_ADDR, 32'(GT));
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk_in);
      first_table_in <= 4'(i);
      second_table_in <= 4'(15 - i);
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(32'(comb_x_out), 32'(FT[i]));
      chk(32'(comb_y_out), 32'(GT[15 - i]));
    end
    wr(LC_FIRST_CFG_ADDR, 32'h0000_6996);
    wr(LC_SECOND_CFG_ADDR, 32'h0000_6996);
    wr(LC_THIRD_CFG_ADDR, 32'h0000_0096);
    wr(LC_MODE_CFG_ADDR, 32'h0000_0C00);
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk_in);
      {first_table_in, second_table_in} <= {4'(i), 4'(i + 3)};
      third_table_dedicated_input_in <= i[4];
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(32'({comb_x_out, comb_y_out}),
          32'({2{^{4'(i), 4'(i + 3), i[4]}}}));
    end
    wr(LC_THIRD_CFG_ADDR, 32'(TT));
    wr(LC_MODE_CFG_ADDR, 32'h0000_012F);
    for (int j = 0; j < 8; j++) begin
      @(posedge ref_clk_in);
      {third_table_dedicated_input_in, third_table_alt_b_in,
       third_table_alt_a_in} <= 3'(j);
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(32'(third_table_out), 32'(TT[j]));
    end
    @(posedge ref_clk_in);
    {third_table_dedicated_input_in, third_table_alt_b_in,
     third_table_alt_a_in} <= 3'h2;
    ph(5'h10, 2'h2);
    ph(5'h06, 2'h1);
    ph(5'h07, 2'h1);
    ph(5'h01, 2'h1);
    ph(5'h03, 2'h1);
    ph(5'h08, 2'h2);
    wr(LC_MODE_CFG_ADDR, 32'h0000_03EF);
    rd(LC_MODE_CFG_ADDR, 32'h0000_03EF);
    ph(5'h06, 2'h1);
    ph(5'h07, 2'h3);
    ph(5'h04, 2'h1);
    ph(5'h10, 2'h3);
    rd(LC_STATUS_ADDR, 32'h0000_001B);
    end_sim();
  end
endmodule
`default_nettype wire
